// ### sldo_cfg.svh
// Constants for the slew limited dual output register block
`ifndef SLDO_CFG_SVH
`define SLDO_CFG_SVH

// System clock
`define SLDO_CLK_HZ          10000000

// Millisecond tick: time in ms and cycles derived from the clock
`define SLDO_MS_TIME         1
`define SLDO_MS_CYC          (`SLDO_CLK_HZ / 1000 * `SLDO_MS_TIME)

// Holding register addresses
`define SLDO_ADR_STATION     16'h9c41
`define SLDO_ADR_SERIAL      16'h9c42
`define SLDO_ADR_DELAYS      16'h9c43
`define SLDO_ADR_FW_REV      16'h9c61
`define SLDO_ADR_SETPT_CH1   16'h9c71
`define SLDO_ADR_SETPT_CH2   16'h9c72
`define SLDO_ADR_SLEW_CH1    16'h9c81
`define SLDO_ADR_SLEW_CH2    16'h9c82
`define SLDO_ADR_RDBK_CH1    16'h9ca1
`define SLDO_ADR_RDBK_CH2    16'h9ca2
`define SLDO_ADR_PRES_CH1    16'h9cb1
`define SLDO_ADR_PRES_CH2    16'h9cb2

// Reset values
`define SLDO_STATION_RST     16'h0001
`define SLDO_SERIAL_RST      16'h0035
`define SLDO_DELAYS_RST      16'h0003
`define SLDO_SLEW_CH2_RST    16'h0000
`define SLDO_SETPT_RST       16'h0000
`define SLDO_FW_REV_DEF      16'h0100

// Legal value limits
`define SLDO_STATION_MIN     16'h0001
`define SLDO_STATION_MAX     16'h00df
`define SLDO_BAUD_CODE_MIN   4'h5
`define SLDO_BAUD_CODE_MAX   4'h9
`define SLDO_RSP_DLY_MAX     8'h3f
`define SLDO_EOQ_DLY_MAX     8'h30
`define SLDO_SLEW_MAX        16'h0012

// Field positions
`define SLDO_RSP_DLY_MSB     7
`define SLDO_RSP_DLY_LSB     0
`define SLDO_EOQ_DLY_MSB     15
`define SLDO_EOQ_DLY_LSB     8
`define SLDO_BAUD_MSB        3
`define SLDO_BAUD_LSB        0
`define SLDO_SLEW_MSB        4
`define SLDO_SLEW_LSB        0

// Baud rates per code 5 to 9 and bit times in cycles
`define SLDO_BAUD_5          9600
`define SLDO_BAUD_6          19200
`define SLDO_BAUD_7          38400
`define SLDO_BAUD_8          57600
`define SLDO_BAUD_9          115200
`define SLDO_BIT_CYC_5       (`SLDO_CLK_HZ / `SLDO_BAUD_5)
`define SLDO_BIT_CYC_6       (`SLDO_CLK_HZ / `SLDO_BAUD_6)
`define SLDO_BIT_CYC_7       (`SLDO_CLK_HZ / `SLDO_BAUD_7)
`define SLDO_BIT_CYC_8       (`SLDO_CLK_HZ / `SLDO_BAUD_8)
`define SLDO_BIT_CYC_9       (`SLDO_CLK_HZ / `SLDO_BAUD_9)

// Silent gap: 3.5 characters, in tenths, of ten bits each
`define SLDO_GAP_TENTHS      35
`define SLDO_CHAR_BITS       10
`define SLDO_GAP_BITS        (`SLDO_GAP_TENTHS * `SLDO_CHAR_BITS / 10)

// Slope code 1: 0.15625 % of 65536 codes per second, as a Q16.16 fraction per ms
`define SLDO_SLEW_BASE_Q16   32'h00001a37

// Exception answers
`define SLDO_EXC_NONE        8'h00
`define SLDO_EXC_ADDR        8'h02
`define SLDO_EXC_VALUE       8'h03

`endif

// ### sldo_pkg.sv
// Types shared by the slew limited dual output register block
`default_nettype none

package sldo_pkg;

  typedef struct packed {
    logic        write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } sldo_req_type;

  typedef struct packed {
    logic [15:0] data;
    logic [7:0]  exc;
  } sldo_rsp_type;

  typedef enum logic [1:0] {
    GAP_IDLE,
    GAP_BITS,
    GAP_EXTRA
  } sldo_gap_state_type;

  typedef enum logic {
    RSP_IDLE,
    RSP_WAIT
  } sldo_rsp_state_type;

endpackage : sldo_pkg

`default_nettype wire

// ### sldo_slew_chan.sv
// One output channel slewing its present value toward the setpoint
`include "sldo_cfg.svh"
`default_nettype none

module sldo_slew_chan (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        tick,
  input  wire logic [15:0] setpoint,
  input  wire logic [15:0] slew_code,
  output logic      [15:0] present
);
  import sldo_pkg::*;

  logic [31:0] pos_q;
  logic [31:0] pos_d;
  logic [31:0] target;
  logic [31:0] step;
  logic [4:0]  code;

  assign present = pos_q[31:16];

  always_comb
  begin
    code   = slew_code[`SLDO_SLEW_MSB:`SLDO_SLEW_LSB];
    target = {setpoint, 16'h0000};
    step   = 32'h00000000;
    pos_d  = pos_q;
    if (code == 5'h00)
    begin
      pos_d = target;
    end
    else
    begin
      // Rate doubles per code; step is a fixed share of span
      step = `SLDO_SLEW_BASE_Q16 << (code - 5'h01);
      if (tick)
      begin
        if (target > pos_q)
        begin
          if ((target - pos_q) <= step)
            pos_d = target;
          else
            pos_d = pos_q + step;
        end
        else if (target < pos_q)
        begin
          if ((pos_q - target) <= step)
            pos_d = target;
          else
            pos_d = pos_q - step;
        end
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      pos_q <= {`SLDO_SETPT_RST, 16'h0000};
    else
      pos_q <= pos_d;
  end

endmodule : sldo_slew_chan

`default_nettype wire

// ### sldo_frame_timer.sv
// End of frame detection and reply delay timing
`include "sldo_cfg.svh"
`default_nettype none

module sldo_frame_timer (
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       bit_tick,
  input  wire logic       ms_tick,
  input  wire logic       rx_char,
  input  wire logic [7:0] eoq_ms,
  input  wire logic       reply_req,
  input  wire logic [7:0] rsp_ms,
  output logic            frame_end,
  output logic            reply_go
);
  import sldo_pkg::*;

  localparam logic [7:0] GAP_LEN = 8'(`SLDO_GAP_BITS);

  sldo_gap_state_type gap_q;
  sldo_gap_state_type gap_d;
  sldo_rsp_state_type rst_q;
  sldo_rsp_state_type rst_d;
  logic [7:0]         gcnt_q;
  logic [7:0]         gcnt_d;
  logic [7:0]         rcnt_q;
  logic [7:0]         rcnt_d;
  logic               fend_d;
  logic               rgo_d;

  always_comb
  begin
    gap_d  = gap_q;
    gcnt_d = gcnt_q;
    fend_d = 1'b0;
    unique case (gap_q)
      GAP_IDLE: ;
      GAP_BITS:
        if (bit_tick)
        begin
          gcnt_d = gcnt_q + 8'h01;
          if (gcnt_d == GAP_LEN)
          begin
            gcnt_d = 8'h00;
            if (eoq_ms == 8'h00)
            begin
              fend_d = 1'b1;
              gap_d  = GAP_IDLE;
            end
            else
              gap_d = GAP_EXTRA;
          end
        end
      GAP_EXTRA:
        if (ms_tick)
        begin
          gcnt_d = gcnt_q + 8'h01;
          if (gcnt_d >= eoq_ms)
          begin
            fend_d = 1'b1;
            gap_d  = GAP_IDLE;
          end
        end
    endcase
    // Any new character restarts the silence measurement
    if (rx_char)
    begin
      gap_d  = GAP_BITS;
      gcnt_d = 8'h00;
      fend_d = 1'b0;
    end
  end

  always_comb
  begin
    rst_d  = rst_q;
    rcnt_d = rcnt_q;
    rgo_d  = 1'b0;
    unique case (rst_q)
      RSP_IDLE:
        if (reply_req)
        begin
          rcnt_d = 8'h00;
          if (rsp_ms == 8'h00)
            rgo_d = 1'b1;
          else
            rst_d = RSP_WAIT;
        end
      RSP_WAIT:
        if (ms_tick)
        begin
          rcnt_d = rcnt_q + 8'h01;
          if (rcnt_d >= rsp_ms)
          begin
            rgo_d = 1'b1;
            rst_d = RSP_IDLE;
          end
        end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      gap_q     <= GAP_IDLE;
      gcnt_q    <= 8'h00;
      rst_q     <= RSP_IDLE;
      rcnt_q    <= 8'h00;
      frame_end <= 1'b0;
      reply_go  <= 1'b0;
    end
    else
    begin
      gap_q     <= gap_d;
      gcnt_q    <= gcnt_d;
      rst_q     <= rst_d;
      rcnt_q    <= rcnt_d;
      frame_end <= fend_d;
      reply_go  <= rgo_d;
    end
  end

endmodule : sldo_frame_timer

`default_nettype wire

// ### sldo_regs.sv
// Holding register file and slew control for two analog outputs
//
// Function
// - Station address 1..DF, resets to 0001
// - Serial setup resets to 0035, 9600 8N1
// - Low delay byte: reply wait, max 63
// - High delay byte: extra end wait, max 48
// - 3.5 character silence ends a request
// - Setpoint 0 negative, FFFF positive full scale
// - Slope code 0..12 hex, doubling rates
// - Slew rate is share of selected span
// - Slope writes act now, reset reloads stored
// - Second slope register resets to zero
// - Readback registers show eight bit measurement
// - Present value shows slewing converter code
// - Firmware revision fixed, not writable
`include "sldo_cfg.svh"
`default_nettype none

module sldo_regs #(
  parameter int          MS_CYC      = `SLDO_MS_CYC,
  // Revision value is arbitrary
  parameter logic [15:0] FW_REVISION = `SLDO_FW_REV_DEF
) (
  input  wire logic                  clock,
  input  wire logic                  reset,
  input  wire logic                  req_valid,
  input  wire sldo_pkg::sldo_req_type req,
  output logic                       rsp_valid,
  output sldo_pkg::sldo_rsp_type     rsp,
  input  wire logic                  rx_char,
  input  wire logic                  reply_req,
  output logic                       frame_end,
  output logic                       reply_go,
  input  wire logic [15:0]           nv_slew_ch1,
  input  wire logic [7:0]            adc_ch1,
  input  wire logic [7:0]            adc_ch2,
  output logic      [15:0]           station_address,
  output logic      [15:0]           serial_setup,
  output logic      [15:0]           dac_code_ch1,
  output logic      [15:0]           dac_code_ch2
);
  import sldo_pkg::*;

  localparam logic [15:0] MS_LAST = 16'(MS_CYC - 1);

  // Register state
  logic [15:0]  station_q;
  logic [15:0]  station_d;
  logic [15:0]  serial_q;
  logic [15:0]  serial_d;
  logic [15:0]  delays_q;
  logic [15:0]  delays_d;
  logic [15:0]  setpt1_q;
  logic [15:0]  setpt1_d;
  logic [15:0]  setpt2_q;
  logic [15:0]  setpt2_d;
  logic [15:0]  slew1_q;
  logic [15:0]  slew1_d;
  logic [15:0]  slew2_q;
  logic [15:0]  slew2_d;
  logic [7:0]   rdbk1_q;
  logic [7:0]   rdbk2_q;

  // Answer state
  logic         rsp_valid_d;
  sldo_rsp_type rsp_d;

  // Dividers
  logic [15:0]  ms_cnt_q;
  logic [15:0]  ms_cnt_d;
  logic         ms_tick_q;
  logic         ms_tick_d;
  logic [15:0]  bit_cnt_q;
  logic [15:0]  bit_cnt_d;
  logic         bit_tick_q;
  logic         bit_tick_d;
  logic [15:0]  bit_last;

  logic [15:0]  pres1;
  logic [15:0]  pres2;
  logic         wr_ok;
  logic         hit_rw;

  assign station_address = station_q;
  assign serial_setup    = serial_q;
  assign dac_code_ch1    = pres1;
  assign dac_code_ch2    = pres2;

  // Bit time follows the selected baud code
  always_comb
  begin
    unique case (serial_q[`SLDO_BAUD_MSB:`SLDO_BAUD_LSB])
      4'h6:    bit_last = 16'(`SLDO_BIT_CYC_6 - 1);
      4'h7:    bit_last = 16'(`SLDO_BIT_CYC_7 - 1);
      4'h8:    bit_last = 16'(`SLDO_BIT_CYC_8 - 1);
      4'h9:    bit_last = 16'(`SLDO_BIT_CYC_9 - 1);
      default: bit_last = 16'(`SLDO_BIT_CYC_5 - 1);
    endcase
  end

  // Millisecond and bit enables
  always_comb
  begin
    ms_tick_d  = 1'b0;
    ms_cnt_d   = ms_cnt_q + 16'h0001;
    if (ms_cnt_q >= MS_LAST)
    begin
      ms_cnt_d  = 16'h0000;
      ms_tick_d = 1'b1;
    end
    bit_tick_d = 1'b0;
    bit_cnt_d  = bit_cnt_q + 16'h0001;
    if (bit_cnt_q >= bit_last)
    begin
      bit_cnt_d  = 16'h0000;
      bit_tick_d = 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      ms_cnt_q   <= 16'h0000;
      ms_tick_q  <= 1'b0;
      bit_cnt_q  <= 16'h0000;
      bit_tick_q <= 1'b0;
    end
    else
    begin
      ms_cnt_q   <= ms_cnt_d;
      ms_tick_q  <= ms_tick_d;
      bit_cnt_q  <= bit_cnt_d;
      bit_tick_q <= bit_tick_d;
    end
  end

  // Register access: decode, value check, write and read answer
  always_comb
  begin
    station_d   = station_q;
    serial_d    = serial_q;
    delays_d    = delays_q;
    setpt1_d    = setpt1_q;
    setpt2_d    = setpt2_q;
    slew1_d     = slew1_q;
    slew2_d     = slew2_q;
    rsp_valid_d = req_valid;
    rsp_d.data  = 16'h0000;
    rsp_d.exc   = `SLDO_EXC_NONE;
    wr_ok       = 1'b0;
    hit_rw      = 1'b1;
    unique case (req.addr)
      `SLDO_ADR_STATION:
      begin
        rsp_d.data = station_q;
        wr_ok = (req.wdata >= `SLDO_STATION_MIN) &&
                (req.wdata <= `SLDO_STATION_MAX);
      end
      `SLDO_ADR_SERIAL:
      begin
        rsp_d.data = serial_q;
        wr_ok = (req.wdata[`SLDO_BAUD_MSB:`SLDO_BAUD_LSB] >=
                 `SLDO_BAUD_CODE_MIN) &&
                (req.wdata[`SLDO_BAUD_MSB:`SLDO_BAUD_LSB] <=
                 `SLDO_BAUD_CODE_MAX);
      end
      `SLDO_ADR_DELAYS:
      begin
        rsp_d.data = delays_q;
        wr_ok = (req.wdata[`SLDO_RSP_DLY_MSB:`SLDO_RSP_DLY_LSB] <=
                 `SLDO_RSP_DLY_MAX) &&
                (req.wdata[`SLDO_EOQ_DLY_MSB:`SLDO_EOQ_DLY_LSB] <=
                 `SLDO_EOQ_DLY_MAX);
      end
      `SLDO_ADR_SETPT_CH1:
      begin
        rsp_d.data = setpt1_q;
        wr_ok = 1'b1;
      end
      `SLDO_ADR_SETPT_CH2:
      begin
        rsp_d.data = setpt2_q;
        wr_ok = 1'b1;
      end
      `SLDO_ADR_SLEW_CH1:
      begin
        rsp_d.data = slew1_q;
        wr_ok = (req.wdata <= `SLDO_SLEW_MAX);
      end
      `SLDO_ADR_SLEW_CH2:
      begin
        rsp_d.data = slew2_q;
        wr_ok = (req.wdata <= `SLDO_SLEW_MAX);
      end
      `SLDO_ADR_FW_REV:
      begin
        rsp_d.data = FW_REVISION;
        hit_rw = 1'b0;
      end
      `SLDO_ADR_RDBK_CH1:
      begin
        rsp_d.data = {rdbk1_q, 8'h00};
        hit_rw = 1'b0;
      end
      `SLDO_ADR_RDBK_CH2:
      begin
        rsp_d.data = {rdbk2_q, 8'h00};
        hit_rw = 1'b0;
      end
      `SLDO_ADR_PRES_CH1:
      begin
        rsp_d.data = pres1;
        hit_rw = 1'b0;
      end
      `SLDO_ADR_PRES_CH2:
      begin
        rsp_d.data = pres2;
        hit_rw = 1'b0;
      end
      default:
      begin
        rsp_d.exc = `SLDO_EXC_ADDR;
        hit_rw = 1'b0;
      end
    endcase
    if (req_valid && req.write)
    begin
      rsp_d.data = req.wdata;
      if (!hit_rw)
        rsp_d.exc = `SLDO_EXC_ADDR;
      else if (!wr_ok)
        rsp_d.exc = `SLDO_EXC_VALUE;
      else
      begin
        unique case (req.addr)
          `SLDO_ADR_STATION:   station_d = req.wdata;
          `SLDO_ADR_SERIAL:    serial_d  = req.wdata;
          `SLDO_ADR_DELAYS:    delays_d  = req.wdata;
          `SLDO_ADR_SETPT_CH1: setpt1_d  = req.wdata;
          `SLDO_ADR_SETPT_CH2: setpt2_d  = req.wdata;
          `SLDO_ADR_SLEW_CH1:  slew1_d   = req.wdata;
          `SLDO_ADR_SLEW_CH2:  slew2_d   = req.wdata;
          default: ;
        endcase
      end
    end
    if (!req_valid)
    begin
      rsp_d.data = 16'h0000;
      rsp_d.exc  = `SLDO_EXC_NONE;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      station_q <= `SLDO_STATION_RST;
      serial_q  <= `SLDO_SERIAL_RST;
      delays_q  <= `SLDO_DELAYS_RST;
      setpt1_q  <= `SLDO_SETPT_RST;
      setpt2_q  <= `SLDO_SETPT_RST;
      // Stored slope reloaded; an illegal stored code means immediate
      if (nv_slew_ch1 <= `SLDO_SLEW_MAX)
        slew1_q <= nv_slew_ch1;
      else
        slew1_q <= 16'h0000;
      slew2_q   <= `SLDO_SLEW_CH2_RST;
      rdbk1_q   <= 8'h00;
      rdbk2_q   <= 8'h00;
      rsp_valid <= 1'b0;
      rsp       <= '0;
    end
    else
    begin
      station_q <= station_d;
      serial_q  <= serial_d;
      delays_q  <= delays_d;
      setpt1_q  <= setpt1_d;
      setpt2_q  <= setpt2_d;
      slew1_q   <= slew1_d;
      slew2_q   <= slew2_d;
      rdbk1_q   <= adc_ch1;
      rdbk2_q   <= adc_ch2;
      rsp_valid <= rsp_valid_d;
      rsp       <= rsp_d;
    end
  end

  // Channel slewing toward the setpoints
  sldo_slew_chan u_chan1 (
    .clock     (clock),
    .reset     (reset),
    .tick      (ms_tick_q),
    .setpoint  (setpt1_q),
    .slew_code (slew1_q),
    .present   (pres1)
  );

  sldo_slew_chan u_chan2 (
    .clock     (clock),
    .reset     (reset),
    .tick      (ms_tick_q),
    .setpoint  (setpt2_q),
    .slew_code (slew2_q),
    .present   (pres2)
  );

  // Request end and reply timing
  sldo_frame_timer u_timer (
    .clock     (clock),
    .reset     (reset),
    .bit_tick  (bit_tick_q),
    .ms_tick   (ms_tick_q),
    .rx_char   (rx_char),
    .eoq_ms    (delays_q[`SLDO_EOQ_DLY_MSB:`SLDO_EOQ_DLY_LSB]),
    .reply_req (reply_req),
    .rsp_ms    (delays_q[`SLDO_RSP_DLY_MSB:`SLDO_RSP_DLY_LSB]),
    .frame_end (frame_end),
    .reply_go  (reply_go)
  );

endmodule : sldo_regs

`default_nettype wire

// ### sldo_regs_monitor.sv
// Concurrent checks on the register block ports
`include "sldo_cfg.svh"
`default_nettype none

module sldo_regs_monitor #(
  parameter int          MS_CYC      = `SLDO_MS_CYC,
  parameter logic [15:0] FW_REVISION = `SLDO_FW_REV_DEF
) (
  input wire logic                   clock,
  input wire logic                   reset,
  input wire logic                   req_valid,
  input wire sldo_pkg::sldo_req_type req,
  input wire sldo_pkg::sldo_rsp_type rsp,
  input wire logic                   rx_char,
  input wire logic                   frame_end,
  input wire logic [15:0]            station_address,
  input wire logic [15:0]            dac_code_ch1,
  input wire logic [15:0]            dac_code_ch2
);
  timeunit 1ns;
  timeprecision 1ns;
  import sldo_pkg::*;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  logic        wr;
  logic        rd;
  logic [15:0] sp1_q;
  logic [15:0] sp1_d;
  logic        fast2_q;
  logic        fast2_d;

  assign wr = req_valid && req.write;
  assign rd = req_valid && !req.write;

  // Shadow of setpoint one and of slope two being zero
  always_comb
  begin
    sp1_d = sp1_q;
    fast2_d = fast2_q;
    if (wr && req.addr == `SLDO_ADR_SETPT_CH1)
      sp1_d = req.wdata;
    if (wr && req.addr == `SLDO_ADR_SLEW_CH2 && req.wdata <= 16'h0012)
      fast2_d = (req.wdata == 16'h0000);
    if (reset)
    begin
      sp1_d = 16'h0000;
      fast2_d = 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    sp1_q <= sp1_d;
    fast2_q <= fast2_d;
  end

  sequence s_sp2_write;
    wr && req.addr == `SLDO_ADR_SETPT_CH2 && fast2_q ##1 !wr;
  endsequence

  a_station_reset: assert property (
    $fell(reset) |-> station_address == 16'h0001)
    else $error("station address not 0001 after reset");
  a_station_range: assert property (
    wr && req.addr == `SLDO_ADR_STATION
    && (req.wdata == 16'h0000 || req.wdata > 16'h00df)
    |=> rsp.exc == 8'h03 && $stable(station_address))
    else $error("station address range not enforced");
  a_delay_limit: assert property (
    wr && req.addr == `SLDO_ADR_DELAYS
    && (req.wdata[7:0] > 8'h3f || req.wdata[15:8] > 8'h30)
    |=> rsp.exc == 8'h03)
    else $error("delay limit not enforced");
  a_slew_limit: assert property (
    wr && (req.addr == `SLDO_ADR_SLEW_CH1 || req.addr == `SLDO_ADR_SLEW_CH2)
    && req.wdata > 16'h0012 |=> rsp.exc == 8'h03)
    else $error("slope code limit not enforced");
  a_rev_value: assert property (
    rd && req.addr == `SLDO_ADR_FW_REV
    |=> rsp.data == FW_REVISION && rsp.exc == 8'h00)
    else $error("revision read wrong");
  a_rev_locked: assert property (
    wr && req.addr == `SLDO_ADR_FW_REV |=> rsp.exc == 8'h02)
    else $error("revision write not refused");
  a_present_read: assert property (
    rd && req.addr == `SLDO_ADR_PRES_CH1
    |=> rsp.data == $past(dac_code_ch1))
    else $error("present value read wrong");
  a_no_overshoot: assert property (
    $stable(sp1_q) && $past(dac_code_ch1) <= sp1_q
    |-> dac_code_ch1 <= sp1_q && dac_code_ch1 >= $past(dac_code_ch1))
    else $error("output moved past setpoint");
  a_immediate_ch2: assert property (
    s_sp2_write |=> dac_code_ch2 == $past(req.wdata, 2))
    else $error("slope zero output not immediate");
  a_frame_quiet: assert property (
    rx_char |-> ##2 (!frame_end) [*8])
    else $error("frame ended without silence");
endmodule : sldo_regs_monitor

bind sldo_regs sldo_regs_monitor #(.MS_CYC(MS_CYC), .FW_REVISION(FW_REVISION))
  u_mon (.clock(clock), .reset(reset), .req_valid(req_valid), .req(req),
    .rsp(rsp), .rx_char(rx_char), .frame_end(frame_end),
    .station_address(station_address), .dac_code_ch1(dac_code_ch1),
    .dac_code_ch2(dac_code_ch2));

`default_nettype wire

// ### sldo_host.sv
// Host model issuing holding register requests and received characters
`default_nettype none

module sldo_host (
  input  wire logic                   clock,
  input  wire logic                   rsp_valid,
  input  wire sldo_pkg::sldo_rsp_type rsp,
  output logic                        req_valid,
  output sldo_pkg::sldo_req_type      req,
  output logic                        rx_char
);
  timeunit 1ns;
  timeprecision 1ns;
  import sldo_pkg::*;

  initial
  begin
    req_valid = 1'b0;
    req = '0;
    rx_char = 1'b0;
  end

  // Up to two requests on consecutive edges, answers collected in order
  task automatic run(input sldo_req_type q [2], input int n,
                     output sldo_rsp_type r [2], output logic v [2]);
    for (int i = 0; i < n + 2; i++)
    begin
      @(posedge clock);
      if (i >= 2)
      begin
        r[i - 2] = rsp;
        v[i - 2] = rsp_valid;
      end
      req_valid <= (i < n);
      if (i < n)
        req <= q[i];
      else
        req <= ~q[n - 1];
    end
  endtask : run

  task automatic chr();
    @(posedge clock);
    rx_char <= 1'b1;
    @(posedge clock);
    rx_char <= 1'b0;
  endtask : chr
endmodule : sldo_host

`default_nettype wire

// ### sldo_regs_test.sv
// Self-checking bench for the slew limited dual output register block
`include "sldo_cfg.svh"
`default_nettype none

module sldo_regs_test;
  timeunit 1ns;
  timeprecision 1ns;
  import sldo_pkg::*;

  localparam int          MS  = 20;
  localparam logic [15:0] REV = 16'h0a5c;  // Arbitrary revision value
  localparam int          GAP = 35 * `SLDO_BIT_CYC_9 + 48 * MS;

  typedef struct packed {
    logic        w;
    logic [15:0] a;
    logic [15:0] d;
    logic [15:0] x;
    logic [7:0]  e;
  } sldo_row_type;

  logic         clock = 1'b0;
  logic         reset = 1'b1;
  logic         reply_req = 1'b0;
  logic [15:0]  nv_slew = 16'h0003;
  logic [7:0]   adc1 = 8'h5a;
  logic [7:0]   adc2 = 8'hc3;
  logic         req_valid, rx_char, rsp_valid, frame_end, reply_go;
  logic [15:0]  station, serial, dac1, dac2;
  sldo_req_type req;
  sldo_rsp_type rsp;
  sldo_rsp_type r [2];
  logic         v [2];
  int           failures = 0;
  int           compares = 0;
  int           n;
  sldo_row_type rows [25];

  always #50 clock = ~clock;

  sldo_host u_host (.clock(clock), .rsp_valid(rsp_valid), .rsp(rsp),
    .req_valid(req_valid), .req(req), .rx_char(rx_char));

  sldo_regs #(.MS_CYC(MS), .FW_REVISION(REV)) u_dut (
    .clock(clock), .reset(reset), .req_valid(req_valid), .req(req),
    .rsp_valid(rsp_valid), .rsp(rsp), .rx_char(rx_char),
    .reply_req(reply_req), .frame_end(frame_end), .reply_go(reply_go),
    .nv_slew_ch1(nv_slew), .adc_ch1(adc1), .adc_ch2(adc2),
    .station_address(station), .serial_setup(serial),
    .dac_code_ch1(dac1), .dac_code_ch2(dac2));

  task automatic results();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic acc(input logic w, input logic [15:0] a,
                     input logic [15:0] d);
    u_host.run('{'{w, a, d}, '{w, a, d}}, 1, r, v);
  endtask : acc

  task automatic rst(input logic [15:0] nv);
    @(posedge clock);
    nv_slew <= nv;
    reset <= 1'b1;
    @(posedge clock);
    reset <= 1'b0;
  endtask : rst

  task automatic wait_sig(input logic sel, input int lim, output int k);
    k = 0;
    do
    begin
      @(posedge clock);
      k++;
    end
    while ((sel ? reply_go : frame_end) !== 1'b1 && k < lim);
    if (k >= lim)
    begin
      failures++;
      results();
    end
  endtask : wait_sig

  task automatic pulse_reply();
    @(posedge clock);
    reply_req <= 1'b1;
    @(posedge clock);
    reply_req <= 1'b0;
  endtask : pulse_reply

  initial
  begin
    rows = '{
      '{1'b0, `SLDO_ADR_STATION, 16'h0000, 16'h0001, 8'h00},
      '{1'b0, `SLDO_ADR_SERIAL, 16'h0000, 16'h0035, 8'h00},
      '{1'b0, `SLDO_ADR_DELAYS, 16'h0000, 16'h0003, 8'h00},
      '{1'b0, `SLDO_ADR_SLEW_CH2, 16'h0000, 16'h0000, 8'h00},
      '{1'b0, `SLDO_ADR_SLEW_CH1, 16'h0000, 16'h0003, 8'h00},
      '{1'b0, `SLDO_ADR_FW_REV, 16'h0000, REV, 8'h00},
      '{1'b1, `SLDO_ADR_FW_REV, 16'h1234, 16'h1234, 8'h02},
      '{1'b1, `SLDO_ADR_STATION, 16'h00df, 16'h00df, 8'h00},
      '{1'b1, `SLDO_ADR_STATION, 16'h00e0, 16'h00e0, 8'h03},
      '{1'b1, `SLDO_ADR_STATION, 16'h0000, 16'h0000, 8'h03},
      '{1'b0, `SLDO_ADR_STATION, 16'h0000, 16'h00df, 8'h00},
      '{1'b1, `SLDO_ADR_DELAYS, 16'h3040, 16'h3040, 8'h03},
      '{1'b1, `SLDO_ADR_DELAYS, 16'h313f, 16'h313f, 8'h03},
      '{1'b1, `SLDO_ADR_SLEW_CH2, 16'h0013, 16'h0013, 8'h03},
      '{1'b1, `SLDO_ADR_SERIAL, 16'h0034, 16'h0034, 8'h03},
      '{1'b1, `SLDO_ADR_SERIAL, 16'h0036, 16'h0036, 8'h00},
      '{1'b1, `SLDO_ADR_SERIAL, 16'h0037, 16'h0037, 8'h00},
      '{1'b1, `SLDO_ADR_SERIAL, 16'h0038, 16'h0038, 8'h00},
      '{1'b0, `SLDO_ADR_SERIAL, 16'h0000, 16'h0038, 8'h00},
      '{1'b0, `SLDO_ADR_RDBK_CH1, 16'h0000, 16'h5a00, 8'h00},
      '{1'b0, `SLDO_ADR_RDBK_CH2, 16'h0000, 16'hc300, 8'h00},
      '{1'b1, `SLDO_ADR_RDBK_CH2, 16'h0000, 16'h0000, 8'h02},
      '{1'b0, 16'h9c44, 16'h0000, 16'h0000, 8'h02},
      '{1'b0, `SLDO_ADR_PRES_CH1, 16'h0000, 16'h0000, 8'h00},
      '{1'b0, `SLDO_ADR_SETPT_CH1, 16'h0000, 16'h0000, 8'h00}};
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    foreach (rows[i])
    begin
      acc(rows[i].w, rows[i].a, rows[i].d);
      chk({v[0], r[0].exc}, {1'b1, rows[i].e});
      if (rows[i].w || rows[i].e === 8'h00)
        chk(r[0].data, rows[i].x);
    end
    for (int c = 18; c >= 0; c--)
    begin
      acc(1'b1, `SLDO_ADR_SLEW_CH2, 16'(c));
      chk(r[0].exc, 8'h00);
    end
    $display("test register table done");
    u_host.run('{'{1'b1, `SLDO_ADR_SETPT_CH2, 16'h1234},
                 '{1'b0, `SLDO_ADR_SETPT_CH2, 16'h0000}}, 2, r, v);
    chk(r[1].data, 16'h1234);
    @(posedge clock);
    chk(dac2, 16'h1234);
    $display("test back to back done");
    acc(1'b1, `SLDO_ADR_SLEW_CH1, 16'h0010);
    acc(1'b1, `SLDO_ADR_SETPT_CH1, 16'h2000);
    repeat (MS) @(posedge clock);
    chk(dac1 >= 16'h0d1b && dac1 <= 16'h1a37, 1'b1);
    acc(1'b1, `SLDO_ADR_SLEW_CH1, 16'h0000);
    @(posedge clock);
    chk(dac1, 16'h2000);
    $display("test slewing done");
    rst(16'h0012);
    acc(1'b0, `SLDO_ADR_SLEW_CH1, 16'h0000);
    chk(r[0].data, 16'h0012);
    chk(station, 16'h0001);
    rst(16'h0013);
    acc(1'b0, `SLDO_ADR_SLEW_CH1, 16'h0000);
    chk(r[0].data, 16'h0000);
    $display("test slope reload done");
    acc(1'b1, `SLDO_ADR_SERIAL, 16'h0039);
    chk(serial, 16'h0039);
    acc(1'b1, `SLDO_ADR_DELAYS, 16'h3003);
    u_host.chr();
    wait_sig(1'b0, GAP + 200, n);
    chk(n > GAP - 120 && n < GAP + 5, 1'b1);
    pulse_reply();
    wait_sig(1'b1, 200, n);
    chk(n >= 2 * MS && n <= 3 * MS + 2, 1'b1);
    acc(1'b1, `SLDO_ADR_DELAYS, 16'h0000);
    pulse_reply();
    wait_sig(1'b1, 10, n);
    chk(n, 1);
    $display("test frame timing done");
    results();
  end
endmodule : sldo_regs_test

`default_nettype wire
